//--- shared/acc_pkg.sv
// shared constants for the accelerometer two-wire port, both ends
package acc_pkg;

    // ----------------------------------------
    // addressing and register layout
    // ----------------------------------------
    localparam logic [3:0] ADDR_HI = 4'h2;
    localparam logic [7:0] REG_PTR = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam int SLEEP_BIT = 0;
    localparam int SELF_BIT = 1;
    localparam int REF_BIT = 2;
    localparam int THERM_BIT = 3;
    localparam logic [2:0] RD_BYTES = 3'h5;
    localparam int SAMPLE_W = 12;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int MCLK_NS = 25;
    localparam int WAKE_MS = 75;
    localparam int GAP_MS = 20;
    localparam int WAKE_CYC = WAKE_MS * 1000000 / MCLK_NS;
    localparam int GAP_CYC = GAP_MS * 1000000 / MCLK_NS;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * MCLK_NS);

endpackage : acc_pkg

//--- shared/acc_i2c_if.sv
// two-wire bus between host end and sensor end, with pull-up resolution
`timescale 1ns/1ps
`default_nettype none

interface acc_i2c_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // ----------------------------------------
    // wired-and: any enable pulls low
    // ----------------------------------------
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_d_oe);

    modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
    modport device (output sda_d_oe, input scl, input sda);
endinterface : acc_i2c_if

`default_nettype wire

//--- core/acc_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module acc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import acc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acc_sy_t;

    acc_sy_t r_reg;
    acc_sy_t r_next;

    // no reset: the inputs settle before anyone reads q
    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge clk) begin
        r_reg <= r_next;
    end

    assign q = r_reg.s2;
endmodule : acc_sync2

`default_nettype wire

//--- core/acc_dev.sv
// sensor end of the two-wire port: target logic on the link clock
//
// Behaviour
// - target only, answers just its own address
// - only pulls data low or releases it
// - host starts only on an idle bus
// - data changes only while clock low
// - start and stop found with clock high
// - eight bits msb first, then acknowledge
// - seven address bits then direction bit
// - acknowledge own address in ninth pulse
// - address 0010 plus three strap bits
// - pointer byte zero, then control byte, stop
// - host writes wake value before reading
// - sleep bit; wake needs about 75 ms
// - host waits 75 ms after wake
// - bit 1 switches self-check on
// - bit 2 selects reference check mode
// - host averages readings with bit 2 flipped; acc_host and the bench only read, no averaging
// - bit 3 puts temperature in first pair
// - read sends control, x/t pair, y pair
// - twelve-bit samples, upper bits zero
// - host nack then stop ends read
// - host waits 20 ms between acquisitions
`timescale 1ns/1ps
`default_nettype none

module acc_dev #(
    parameter int WAKE_CYCLES = acc_pkg::WAKE_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic lclk,
    acc_i2c_if.device bus,
    input wire logic [2:0] addr_strap,
    input wire logic [acc_pkg::SAMPLE_W-1:0] x_sample,
    input wire logic [acc_pkg::SAMPLE_W-1:0] temp_sample,
    input wire logic [acc_pkg::SAMPLE_W-1:0] y_sample,
    output logic sleep_request,
    output logic selfcheck_enable,
    output logic reference_check_mode,
    output logic thermal_select,
    output logic sensor_ready
);
    import acc_pkg::*;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [4:0] {
        D_IDLE = 5'b00001,
        D_RX = 5'b00010,
        D_ACK = 5'b00100,
        D_TX = 5'b01000,
        D_ACKIN = 5'b10000
    } acc_dst_t;

    typedef struct packed {
        acc_dst_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [1:0] phase;
        logic rd;
        logic [2:0] idx;
        logic acked;
        logic sda_oe;
        logic [7:0] ctrl;
        logic scl_q;
        logic sda_q;
        logic req_tgl;
        logic ack_q;
        logic [3*SAMPLE_W-1:0] snap;
    } acc_dl_t;

    typedef struct packed {
        logic [3*SAMPLE_W-1:0] hold;
        logic ack_tgl;
        logic req_q;
        logic [21:0] wake_cnt;
        logic ready;
    } acc_dm_t;

    acc_dl_t l_reg;
    acc_dl_t l_next;
    acc_dm_t m_reg;
    acc_dm_t m_next;

    logic lrst_n;
    logic scl_s;
    logic sda_s;
    logic [2:0] addr_s;
    logic ack_s;
    logic req_s;
    logic [3:0] ctrl_s;

    // ----------------------------------------
    // crossings
    // ----------------------------------------
    acc_sync2 #(.W(1)) u_rst_sync (
        .clk(lclk),
        .d(nrst),
        .q(lrst_n)
    );

    acc_sync2 #(.W(6)) u_link_sync (
        .clk(lclk),
        .d({bus.scl, bus.sda, addr_strap, m_reg.ack_tgl}),
        .q({scl_s, sda_s, addr_s, ack_s})
    );

    // control bits are quasi-static levels, each bit crosses on its own
    acc_sync2 #(.W(5)) u_core_sync (
        .clk(mclk),
        .d({l_reg.req_tgl, l_reg.ctrl[3:0]}),
        .q({req_s, ctrl_s})
    );

    // ----------------------------------------
    // byte served at each read position
    // ----------------------------------------
    function automatic logic [7:0] byte_at(input logic [2:0] i, input logic [7:0] c,
                                           input logic [3*SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] xt;
        logic [SAMPLE_W-1:0] yy;
        xt = c[THERM_BIT] ? s[2*SAMPLE_W-1:SAMPLE_W] : s[3*SAMPLE_W-1:2*SAMPLE_W];
        yy = s[SAMPLE_W-1:0];
        case (i)
            3'h0: byte_at = c;
            3'h1: byte_at = {4'h0, xt[11:8]};
            3'h2: byte_at = xt[7:0];
            3'h3: byte_at = {4'h0, yy[11:8]};
            3'h4: byte_at = yy[7:0];
            default: byte_at = 8'h00;
        endcase
    endfunction : byte_at

    // ----------------------------------------
    // link side target
    // ----------------------------------------
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [7:0] nb;

    always_comb begin
        l_next = l_reg;
        nb = 8'h00;
        l_next.scl_q = scl_s;
        l_next.sda_q = sda_s;
        l_next.ack_q = ack_s;
        rise = scl_s & ~l_reg.scl_q;
        fall = ~scl_s & l_reg.scl_q;
        start_c = scl_s & l_reg.scl_q & l_reg.sda_q & ~sda_s;
        stop_c = scl_s & l_reg.scl_q & ~l_reg.sda_q & sda_s;
        if (ack_s != l_reg.ack_q) begin
            l_next.snap = m_reg.hold;
        end
        if (start_c) begin
            l_next.st = D_RX;
            l_next.bitcnt = 4'h0;
            l_next.phase = 2'h0;
            l_next.sda_oe = 1'b0;
        end else if (stop_c) begin
            l_next.st = D_IDLE;
            l_next.sda_oe = 1'b0;
        end else begin
            case (l_reg.st)
                D_IDLE: begin
                    l_next.sda_oe = 1'b0;
                end
                D_RX: begin
                    if (rise && l_reg.bitcnt < 4'h8) begin
                        l_next.sh = {l_reg.sh[6:0], sda_s};
                        l_next.bitcnt = l_reg.bitcnt + 4'h1;
                    end else if (fall && l_reg.bitcnt == 4'h8) begin
                        l_next.st = D_ACK;
                        l_next.sda_oe = 1'b1;
                        case (l_reg.phase)
                            2'h0: begin
                                if (l_reg.sh[7:1] == {ADDR_HI, addr_s}) begin
                                    l_next.rd = l_reg.sh[0];
                                    l_next.idx = 3'h0;
                                    l_next.req_tgl = l_reg.req_tgl ^ l_reg.sh[0];
                                end else begin
                                    l_next.st = D_IDLE;
                                    l_next.sda_oe = 1'b0;
                                end
                            end
                            2'h1: begin
                                if (l_reg.sh != REG_PTR) begin
                                    l_next.st = D_IDLE;
                                    l_next.sda_oe = 1'b0;
                                end
                            end
                            default: begin
                                l_next.ctrl = l_reg.sh;
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    if (fall) begin
                        l_next.sda_oe = 1'b0;
                        l_next.bitcnt = 4'h0;
                        if (l_reg.phase == 2'h0 && l_reg.rd) begin
                            nb = byte_at(3'h0, l_reg.ctrl, l_reg.snap);
                            l_next.st = D_TX;
                            l_next.sh = nb;
                            l_next.sda_oe = ~nb[7];
                        end else if (l_reg.phase == 2'h2) begin
                            l_next.st = D_IDLE; // single writable register
                        end else begin
                            l_next.st = D_RX;
                            l_next.phase = l_reg.phase + 2'h1;
                        end
                    end
                end
                D_TX: begin
                    if (fall) begin
                        if (l_reg.bitcnt == 4'h7) begin
                            l_next.sda_oe = 1'b0;
                            l_next.st = D_ACKIN;
                        end else begin
                            l_next.sh = {l_reg.sh[6:0], 1'b0};
                            l_next.sda_oe = ~l_reg.sh[6];
                            l_next.bitcnt = l_reg.bitcnt + 4'h1;
                        end
                    end
                end
                D_ACKIN: begin
                    if (rise) begin
                        l_next.acked = ~sda_s;
                    end else if (fall) begin
                        if (l_reg.acked && l_reg.idx < RD_BYTES - 3'h1) begin
                            nb = byte_at(l_reg.idx + 3'h1, l_reg.ctrl, l_reg.snap);
                            l_next.idx = l_reg.idx + 3'h1;
                            l_next.sh = nb;
                            l_next.sda_oe = ~nb[7];
                            l_next.bitcnt = 4'h0;
                            l_next.st = D_TX;
                        end else begin
                            l_next.st = D_IDLE;
                        end
                    end
                end
                default: begin
                    l_next.st = D_IDLE;
                    l_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge lclk) begin
        if (!lrst_n) begin
            l_reg <= '0;
            l_reg.st <= D_IDLE;
            l_reg.ctrl <= CTRL_RESET;
            l_reg.scl_q <= 1'b1;
            l_reg.sda_q <= 1'b1;
        end else begin
            l_reg <= l_next;
        end
    end

    assign bus.sda_d_oe = l_reg.sda_oe;

    // ----------------------------------------
    // core side: snapshot and wake timer
    // ----------------------------------------
    always_comb begin
        m_next = m_reg;
        if (req_s != m_reg.req_q) begin
            m_next.hold = {x_sample, temp_sample, y_sample};
            m_next.req_q = req_s;
            m_next.ack_tgl = ~m_reg.ack_tgl;
        end
        if (ctrl_s[SLEEP_BIT]) begin
            m_next.wake_cnt = 22'h0;
            m_next.ready = 1'b0;
        end else if (!m_reg.ready) begin
            m_next.wake_cnt = m_reg.wake_cnt + 22'h1;
            if (m_reg.wake_cnt == 22'(WAKE_CYCLES - 1)) begin
                m_next.ready = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            m_reg <= '0;
        end else begin
            m_reg <= m_next;
        end
    end

    assign sleep_request = ctrl_s[SLEEP_BIT];
    assign selfcheck_enable = ctrl_s[SELF_BIT];
    assign reference_check_mode = ctrl_s[REF_BIT];
    assign thermal_select = ctrl_s[THERM_BIT];
    assign sensor_ready = m_reg.ready;
endmodule : acc_dev

`default_nettype wire

//--- core/acc_host.sv
// host end: controller that makes the bus clock and runs write and read bursts
`timescale 1ns/1ps
`default_nettype none

module acc_host #(
    parameter int WAKE_CYCLES = acc_pkg::WAKE_CYC,
    parameter int GAP_CYCLES = acc_pkg::GAP_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    acc_i2c_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [2:0] cmd_len,
    input wire logic [2:0] cmd_addr_sel,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    output logic rsp_nack,
    output logic busy
);
    import acc_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_START = 5'b00010,
        H_BIT = 5'b00100,
        H_STOP = 5'b01000,
        H_HOLD = 5'b10000
    } acc_hst_t;

    typedef struct packed {
        acc_hst_t st;
        logic [7:0] div;
        logic [1:0] q;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [2:0] byte_no;
        logic rd;
        logic [2:0] len;
        logic [7:0] wdata;
        logic acked;
        logic scl_oe;
        logic sda_oe;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_last;
        logic rsp_nack;
        logic [21:0] hold;
    } acc_hr_t;

    acc_hr_t r_reg;
    acc_hr_t r_next;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic sending;
    logic last;

    acc_sync2 #(.W(2)) u_bus_sync (
        .clk(mclk),
        .d({bus.scl, bus.sda}),
        .q({scl_s, sda_s})
    );

    // ----------------------------------------
    // sequencer, one bus bit in four quarters
    // ----------------------------------------
    assign cmd_ready = (r_reg.st == H_IDLE) && scl_s && sda_s;

    always_comb begin
        r_next = r_reg;
        r_next.rsp_valid = 1'b0;
        r_next.rsp_nack = 1'b0;
        tick = (r_reg.div == 8'(QTR_CYC - 1));
        sending = (r_reg.byte_no == 3'h0) || !r_reg.rd;
        last = r_reg.rd ? (r_reg.byte_no == r_reg.len) : (r_reg.byte_no == 3'h2);
        r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
        if (tick) begin
            r_next.q = r_reg.q + 2'h1;
        end
        case (r_reg.st)
            H_IDLE: begin
                r_next.div = 8'h00;
                r_next.q = 2'h0;
                if (cmd_valid && cmd_ready) begin
                    r_next.st = H_START;
                    r_next.rd = cmd_read;
                    r_next.wdata = cmd_data;
                    r_next.len = (cmd_len == 3'h0) ? 3'h1 :
                                 ((cmd_len > RD_BYTES) ? RD_BYTES : cmd_len);
                    r_next.sh = {ADDR_HI, cmd_addr_sel, cmd_read};
                end
            end
            H_START: begin
                if (tick) begin
                    case (r_reg.q)
                        2'h1: r_next.sda_oe = 1'b1;
                        2'h2: r_next.scl_oe = 1'b1;
                        2'h3: begin
                            r_next.st = H_BIT;
                            r_next.bitcnt = 4'h0;
                            r_next.byte_no = 3'h0;
                        end
                        default: r_next.sda_oe = 1'b0;
                    endcase
                end
            end
            H_BIT: begin
                if (tick) begin
                    case (r_reg.q)
                        2'h0: begin
                            if (r_reg.bitcnt < 4'h8) begin
                                r_next.sda_oe = sending & ~r_reg.sh[7];
                            end else begin
                                r_next.sda_oe = !sending && !last;
                            end
                        end
                        2'h1: r_next.scl_oe = 1'b0;
                        2'h2: begin
                            if (r_reg.bitcnt < 4'h8 && !sending) begin
                                r_next.sh = {r_reg.sh[6:0], sda_s};
                            end else if (r_reg.bitcnt == 4'h8 && sending) begin
                                r_next.acked = ~sda_s;
                            end
                        end
                        default: begin
                            r_next.scl_oe = 1'b1;
                            if (r_reg.bitcnt < 4'h8) begin
                                r_next.bitcnt = r_reg.bitcnt + 4'h1;
                                if (sending) begin
                                    r_next.sh = {r_reg.sh[6:0], 1'b0};
                                end
                            end else begin
                                r_next.bitcnt = 4'h0;
                                r_next.byte_no = r_reg.byte_no + 3'h1;
                                r_next.sh = (r_reg.byte_no == 3'h0) ? REG_PTR :
                                            r_reg.wdata;
                                if (!sending) begin
                                    r_next.rsp_valid = 1'b1;
                                    r_next.rsp_data = r_reg.sh;
                                    r_next.rsp_last = last;
                                end
                                if (sending && !r_reg.acked) begin
                                    r_next.rsp_nack = 1'b1;
                                    r_next.st = H_STOP;
                                end else if (last) begin
                                    r_next.st = H_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            H_STOP: begin
                if (tick) begin
                    case (r_reg.q)
                        2'h0: r_next.sda_oe = 1'b1;
                        2'h1: r_next.scl_oe = 1'b0;
                        2'h2: r_next.sda_oe = 1'b0;
                        default: begin
                            r_next.st = H_HOLD;
                            // spacing after a burst: wake settle or acquisition gap
                            if (!r_reg.acked) begin
                                r_next.hold = 22'h0;
                            end else if (r_reg.rd) begin
                                r_next.hold = 22'(GAP_CYCLES);
                            end else if (!r_reg.wdata[SLEEP_BIT]) begin
                                r_next.hold = 22'(WAKE_CYCLES);
                            end else begin
                                r_next.hold = 22'h0;
                            end
                        end
                    endcase
                end
            end
            H_HOLD: begin
                if (r_reg.hold == 22'h0) begin
                    r_next.st = H_IDLE;
                end else begin
                    r_next.hold = r_reg.hold - 22'h1;
                end
            end
            default: begin
                r_next.st = H_IDLE;
                r_next.scl_oe = 1'b0;
                r_next.sda_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.st <= H_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.scl_m_oe = r_reg.scl_oe;
    assign bus.sda_m_oe = r_reg.sda_oe;
    assign rsp_valid = r_reg.rsp_valid;
    assign rsp_data = r_reg.rsp_data;
    assign rsp_last = r_reg.rsp_last;
    assign rsp_nack = r_reg.rsp_nack;
    assign busy = (r_reg.st != H_IDLE);
endmodule : acc_host

`default_nettype wire

//--- verif/acc_i2c_props.sv
// bus checks for the accelerometer two-wire link
`timescale 1ns/1ps
`default_nettype none
module acc_i2c_props import acc_pkg::*; #(
    parameter logic [2:0] STRAP = 3'h0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    // ----
    // decode helpers
    // ----
    logic scl_q, sda_q, rd;
    logic [5:0] bc;
    logic [7:0] sh, hc;
    wire logic rise = scl & ~scl_q;
    always_ff @(posedge mclk) begin
        scl_q <= scl;
        sda_q <= sda;
        // cleared in reset so the first start is judged against a known count
        hc <= (!nrst || scl_m_oe) ? 8'h00 : (hc == 8'hff ? hc : hc + 8'h01);
        if (!nrst) begin
            bc <= 6'h3f;
            rd <= 1'b0;
        end else if (scl && scl_q && sda_q && !sda) begin
            bc <= 6'h00;
        end else if (rise && bc != 6'h3f) begin
            bc <= bc + 6'h01;
            sh <= {sh[6:0], sda};
            if (bc == 6'h08) rd <= sh[0] && sh[7:1] == {ADDR_HI, STRAP};
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence start_s; scl && $past(scl) && $fell(sda); endsequence
    sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
    a_start_clock_low: assert property (start_s |-> ##[1:30] scl_m_oe)
        else $error("no clock low after start");
    a_start_when_idle: assert property (start_s |-> hc >= 8'h14)
        else $error("start on busy bus");
    a_stop_bus_idle: assert property (stop_s |->
        (!scl_m_oe && !sda_m_oe && !sda_d_oe) [*8])
        else $error("bus not idle after stop");
    a_scl_high_width: assert property ($rose(scl_m_oe) && bc != 6'h00 && bc != 6'h3f
        |-> hc >= 8'h2d && hc <= 8'h37)
        else $error("clock high width off");
    a_own_addr_ack: assert property (rise && bc == 6'h08 && sh[7:1] == {ADDR_HI, STRAP}
        |-> sda_d_oe)
        else $error("own address not acknowledged");
    a_other_addr_quiet: assert property (rise && bc == 6'h08 && sh[7:1] != {ADDR_HI, STRAP}
        |-> !sda_d_oe)
        else $error("foreign address acknowledged");
    a_high_nibble_zero: assert property (rise && rd && (bc inside {[18:21], [36:39]})
        |-> !sda)
        else $error("unused high bits not zero");
    a_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
        else $error("sensor moved data with clock high");
    // a clock high this long only happens on an idle bus, never inside a bit
    a_idle_released: assert property (hc >= 8'h80 |-> !sda_d_oe)
        else $error("sensor drives idle bus");
endmodule : acc_i2c_props
`default_nettype wire

//--- verif/accel_i2c_slave_port_tb.sv
// bench: host end and sensor end joined on one bus
`timescale 1ns/1ps
`default_nettype none
module accel_i2c_slave_port_tb;
    import acc_pkg::*;
    localparam logic [2:0] STRAP = 3'h5;
    logic mclk = 1'b0, lclk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
    logic [2:0] cmd_len = 3'h0, cmd_sel = STRAP;
    logic [7:0] cmd_data = 8'h00, rsp_data;
    logic [11:0] x_s = 12'h9a5, t_s = 12'h3c7, y_s = 12'h5e1;
    logic cmd_ready, rsp_valid, rsp_last, rsp_nack, busy, slp, chk, refm, thm, rdy, last_q, nack_q;
    logic [7:0] got [$];
    int n_fail = 0, cmp_count = 0;
    wire logic [7:0] ctl = {4'h0, thm, refm, chk, slp};
    acc_i2c_if bus_if ();
    acc_host #(.WAKE_CYCLES(50), .GAP_CYCLES(30)) i_acc_host (.mclk(mclk), .nrst(nrst),
        .bus(bus_if.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_len(cmd_len), .cmd_addr_sel(cmd_sel), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_nack(rsp_nack), .busy(busy));
    acc_dev #(.WAKE_CYCLES(50)) i_acc_dev (.mclk(mclk), .nrst(nrst), .lclk(lclk),
        .bus(bus_if.device), .addr_strap(STRAP), .x_sample(x_s), .temp_sample(t_s),
        .y_sample(y_s), .sleep_request(slp), .selfcheck_enable(chk),
        .reference_check_mode(refm), .thermal_select(thm), .sensor_ready(rdy));
    acc_i2c_props #(.STRAP(STRAP)) i_acc_i2c_props (.mclk(mclk), .nrst(nrst),
        .scl_m_oe(bus_if.scl_m_oe), .sda_m_oe(bus_if.sda_m_oe), .sda_d_oe(bus_if.sda_d_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));
    initial forever #12.5 mclk = ~mclk;
    initial forever #24 lclk = ~lclk;
    // ----
    // shared tasks
    // ----
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic run(input logic rd, input logic [2:0] len, input logic [2:0] sel,
        input logic [7:0] data, input logic bump);
        int i;
        got = {};
        nack_q = 1'b0;
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge mclk);
        if (i >= 3000) begin
            n_fail++;
            give_verdict();
        end
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_len = len;
        cmd_sel = sel;
        cmd_data = data;
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
            @(negedge mclk);
            if (rsp_valid === 1'b1) got.push_back(rsp_data);
            if (rsp_valid === 1'b1) last_q = rsp_last;
            if (rsp_nack === 1'b1) nack_q = 1'b1;
            if (bump && got.size() == 1) x_s = 12'h123;
        end
        if (i >= 20000) begin
            n_fail++;
            give_verdict();
        end
        repeat (6) @(negedge mclk);
    endtask : run
    // ----
    // scenarios
    // ----
    task automatic sc_wake();
        int i;
        check("reset ctl", ctl, CTRL_RESET);
        check("reset rdy", {7'h00, rdy}, 8'h00);
        run(1'b0, 3'h0, STRAP, 8'h00, 1'b0);
        check("wake nack", {7'h00, nack_q}, 8'h00);
        check("wake ctl", ctl, 8'h00);
        for (i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge mclk);
        check("wake rdy", {7'h00, rdy}, 8'h01);
    endtask : sc_wake
    task automatic sc_read();
        logic [7:0] exp [5] = '{8'h00, 8'h09, 8'ha5, 8'h05, 8'he1};
        run(1'b1, 3'h5, STRAP, 8'h00, 1'b1);
        check("rd count", 8'(got.size()), 8'h05);
        for (int k = 0; k < 5; k++) check("rd byte", got[k], exp[k]);
        check("rd last", {7'h00, last_q}, 8'h01);
    endtask : sc_read
    task automatic sc_modes();
        run(1'b0, 3'h0, STRAP, 8'h0e, 1'b0);
        check("mode ctl", ctl, 8'h0e);
        run(1'b1, 3'h3, STRAP, 8'h00, 1'b0);
        check("short count", 8'(got.size()), 8'h03);
        check("short ctl", got[0], 8'h0e);
        check("temp high", got[1], 8'h03);
        check("temp low", got[2], 8'hc7);
    endtask : sc_modes
    task automatic sc_foreign_sleep();
        run(1'b0, 3'h0, 3'h2, 8'h01, 1'b0);
        check("foreign nack", {7'h00, nack_q}, 8'h01);
        check("foreign ctl", ctl, 8'h0e);
        run(1'b0, 3'h0, STRAP, 8'h01, 1'b0);
        check("sleep ctl", ctl, 8'h01);
        check("sleep rdy", {7'h00, rdy}, 8'h00);
    endtask : sc_foreign_sleep
    initial begin
        // eight cycles so the link side also sees four edges in reset
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        sc_wake();
        sc_read();
        sc_modes();
        sc_foreign_sleep();
        give_verdict();
    end
endmodule : accel_i2c_slave_port_tb
`default_nettype wire
